/* File: src/param_access_command_unit.sv */
// Parameter access command interpreter: frame intake, parameter stores and replies
`timescale 1ns/1ps
module param_access_command_unit
	import param_cmd_pkg::*;
(
	input  wire logic                  CORE_CLK_IN,      // 125 MHz system clock
	input  wire logic                  RESETN_IN,        // Power-up reset, async, active low
	input  wire logic [7:0]            RX_BYTE_IN,       // Command frame byte
	input  wire logic                  RX_VALID_IN,      // Byte strobe, one cycle
	input  wire logic                  STANDALONE_IN,    // High: standalone mode, no replies
	output logic                       RX_READY_OUT,     // High while bytes are accepted
	output logic                       REPLY_VALID_OUT,  // Reply strobe, one cycle
	output param_cmd_pkg::reply_t      REPLY_OUT,        // Reply status, instruction, value
	output logic [31:0]                ACCU_OUT          // Accumulator register
);
	import param_cmd_pkg::*;

	typedef enum logic [1:0] {ST_INIT, ST_RECV, ST_EXEC} state_t;

	state_t      state_r;
	frame_t      frame_r;
	logic [3:0]  byte_cnt_r;
	logic [7:0]  sum_r;
	logic [7:0]  init_idx_r;

	// Working axis set is volatile; the persistent stores are the EEPROM image and banks 0, 2 and 3
	logic [31:0] axis_mem [PARAM_COUNT];
	logic [31:0] axis_ee  [PARAM_COUNT];
	logic [31:0] bank0_mem [PARAM_COUNT];
	logic [31:0] bank2_mem [PARAM_COUNT];
	logic [31:0] bank3_mem [PARAM_COUNT];

	logic        addr_match;
	logic        csum_ok;
	logic        exec;
	logic        cmd_ok;
	logic [7:0]  status_nxt;
	logic [31:0] axis_rd;
	logic [31:0] ee_rd;
	logic [31:0] glob_rd;
	logic        bank_ok;
	logic        motor_ok;

	assign exec       = (state_r == ST_EXEC);
	assign addr_match = (frame_r.target == bank0_mem[SERIAL_ADDR_PARAM][7:0]);
	assign csum_ok    = (frame_r.csum == sum_r);
	assign axis_rd    = axis_mem[frame_r.ptype];
	assign ee_rd      = axis_ee[frame_r.ptype];
	assign motor_ok   = (frame_r.bank == MOTOR_ONLY);
	assign bank_ok    = (frame_r.bank == BANK_MODULE) || (frame_r.bank == BANK_USER_VARS)
		|| (frame_r.bank == BANK_IRQ_CFG);

	always_comb
	begin
		unique case (frame_r.bank)
			BANK_MODULE:    glob_rd = bank0_mem[frame_r.ptype];
			BANK_USER_VARS: glob_rd = bank2_mem[frame_r.ptype];
			BANK_IRQ_CFG:   glob_rd = bank3_mem[frame_r.ptype];
			default:        glob_rd = 32'h0000_0000;
		endcase
	end

	always_comb
	begin
		status_nxt = STATUS_OK;
		if (!csum_ok)
			status_nxt = STATUS_BAD_CSUM;
		else
			unique case (frame_r.instr)
				INSTR_AXIS_PARAM_WRITE, INSTR_AXIS_PARAM_READ,
				INSTR_AXIS_PARAM_PERSIST, INSTR_AXIS_PARAM_RELOAD:
					if (!motor_ok)
						status_nxt = STATUS_BAD_VALUE;
				INSTR_GLOBAL_PARAM_WRITE, INSTR_GLOBAL_PARAM_READ:
					if (!bank_ok)
						status_nxt = STATUS_BAD_VALUE;
				default:
					status_nxt = STATUS_BAD_INSTR;
			endcase
	end

	assign cmd_ok = exec && addr_match && (status_nxt == STATUS_OK);

	// Sequencer: EEPROM load after power-up, then frame intake and one-cycle execution
	always_ff @(posedge CORE_CLK_IN or negedge RESETN_IN)
	begin
		if (!RESETN_IN)
		begin
			state_r    <= ST_INIT;
			init_idx_r <= 8'h00;
		end
		else
		begin
			unique case (state_r)
				ST_INIT:
				begin
					init_idx_r <= init_idx_r + 8'h01;
					if (init_idx_r == 8'(PARAM_COUNT - 1))
						state_r <= ST_RECV;
				end
				ST_RECV:
					if (RX_READY_OUT && RX_VALID_IN && byte_cnt_r == 4'(FRAME_BYTES - 1))
						state_r <= ST_EXEC;
				ST_EXEC:
					state_r <= ST_RECV;
			endcase
		end
	end

	// Byte assembly: fields shift in order, value most significant first
	always_ff @(posedge CORE_CLK_IN or negedge RESETN_IN)
	begin
		if (!RESETN_IN)
		begin
			frame_r    <= '0;
			byte_cnt_r <= 4'h0;
			sum_r      <= 8'h00;
		end
		else if (RX_READY_OUT && RX_VALID_IN)
		begin
			frame_r <= {frame_r[$bits(frame_t)-9:0], RX_BYTE_IN};
			if (byte_cnt_r == 4'(FRAME_BYTES - 1))
				byte_cnt_r <= 4'h0;
			else
			begin
				byte_cnt_r <= byte_cnt_r + 4'h1;
				sum_r      <= (byte_cnt_r == 4'h0) ? RX_BYTE_IN : 8'(sum_r + RX_BYTE_IN);
			end
		end
	end

	always_ff @(posedge CORE_CLK_IN or negedge RESETN_IN)
	begin
		if (!RESETN_IN)
			RX_READY_OUT <= 1'b0;
		else
			RX_READY_OUT <= (state_r == ST_RECV)
				&& !(RX_READY_OUT && RX_VALID_IN && byte_cnt_r == 4'(FRAME_BYTES - 1));
	end

	// Volatile working set, filled from the EEPROM image at power-up
	always_ff @(posedge CORE_CLK_IN)
	begin
		if (state_r == ST_INIT)
			axis_mem[init_idx_r] <= axis_ee[init_idx_r];
		else if (cmd_ok && frame_r.instr == INSTR_AXIS_PARAM_WRITE)
			axis_mem[frame_r.ptype] <= frame_r.value;
		else if (cmd_ok && frame_r.instr == INSTR_AXIS_PARAM_RELOAD)
			axis_mem[frame_r.ptype] <= ee_rd;
	end

	// EEPROM image and global banks; power-up reset stands for a blank factory image
	always_ff @(posedge CORE_CLK_IN or negedge RESETN_IN)
	begin
		if (!RESETN_IN)
		begin
			for (int i = 0; i < PARAM_COUNT; i++)
			begin
				axis_ee[i]   <= 32'h0000_0000;
				bank0_mem[i] <= (8'(i) == SERIAL_ADDR_PARAM) ? SERIAL_ADDR_RESET : 32'h0000_0000;
				bank2_mem[i] <= 32'h0000_0000;
				bank3_mem[i] <= 32'h0000_0000;
			end
		end
		else if (cmd_ok)
		begin
			if (frame_r.instr == INSTR_AXIS_PARAM_PERSIST)
				axis_ee[frame_r.ptype] <= axis_rd;
			if (frame_r.instr == INSTR_GLOBAL_PARAM_WRITE)
			begin
				unique case (frame_r.bank)
					BANK_MODULE:    bank0_mem[frame_r.ptype] <= frame_r.value;
					BANK_USER_VARS: bank2_mem[frame_r.ptype] <= frame_r.value;
					BANK_IRQ_CFG:   bank3_mem[frame_r.ptype] <= frame_r.value;
					default:        ;
				endcase
			end
		end
	end

	always_ff @(posedge CORE_CLK_IN or negedge RESETN_IN)
	begin
		if (!RESETN_IN)
			ACCU_OUT <= 32'h0000_0000;
		else if (cmd_ok && frame_r.instr == INSTR_AXIS_PARAM_READ && STANDALONE_IN)
			ACCU_OUT <= axis_rd;
		else if (cmd_ok && frame_r.instr == INSTR_GLOBAL_PARAM_READ)
			ACCU_OUT <= glob_rd;
	end

	// Replies only in direct mode and only for frames addressed to this unit
	always_ff @(posedge CORE_CLK_IN or negedge RESETN_IN)
	begin
		if (!RESETN_IN)
		begin
			REPLY_VALID_OUT <= 1'b0;
			REPLY_OUT       <= '0;
		end
		else
		begin
			REPLY_VALID_OUT <= exec && addr_match && !STANDALONE_IN;
			if (exec && addr_match && !STANDALONE_IN)
			begin
				REPLY_OUT.status <= status_nxt;
				REPLY_OUT.instr  <= frame_r.instr;
				if (status_nxt != STATUS_OK)
					REPLY_OUT.value <= 32'h0000_0000;
				else if (frame_r.instr == INSTR_AXIS_PARAM_READ)
					REPLY_OUT.value <= axis_rd;
				else if (frame_r.instr == INSTR_GLOBAL_PARAM_READ)
					REPLY_OUT.value <= glob_rd;
				else
					REPLY_OUT.value <= 32'h0000_0000;
			end
		end
	end

	property p_ok_reply;
		@(posedge CORE_CLK_IN) disable iff (!RESETN_IN)
		cmd_ok && !STANDALONE_IN |=> REPLY_VALID_OUT && REPLY_OUT.status == 8'h64;
	endproperty
	a_ok_reply: assert property (p_ok_reply) else $error("ok command without status 100 reply");

	property p_bad_csum;
		@(posedge CORE_CLK_IN) disable iff (!RESETN_IN)
		exec && addr_match && !csum_ok && !STANDALONE_IN |=> REPLY_VALID_OUT && REPLY_OUT.status == 8'h01
			&& $stable(ACCU_OUT);
	endproperty
	a_bad_csum: assert property (p_bad_csum) else $error("bad checksum not refused");

	property p_foreign_addr;
		@(posedge CORE_CLK_IN) disable iff (!RESETN_IN)
		exec && !addr_match |=> !REPLY_VALID_OUT && $stable(ACCU_OUT);
	endproperty
	a_foreign_addr: assert property (p_foreign_addr) else $error("acted on foreign address");

	property p_axis_write;
		@(posedge CORE_CLK_IN) disable iff (!RESETN_IN)
		cmd_ok && frame_r.instr == 8'h05 |=> axis_mem[$past(frame_r.ptype)] == $past(frame_r.value);
	endproperty
	a_axis_write: assert property (p_axis_write) else $error("axis write not stored");

	property p_axis_read_direct;
		@(posedge CORE_CLK_IN) disable iff (!RESETN_IN)
		cmd_ok && frame_r.instr == 8'h06 && !STANDALONE_IN |=> REPLY_OUT.value == $past(axis_rd) && $stable(ACCU_OUT);
	endproperty
	a_axis_read_direct: assert property (p_axis_read_direct) else $error("direct axis read wrong");

	property p_axis_read_standalone;
		@(posedge CORE_CLK_IN) disable iff (!RESETN_IN)
		cmd_ok && frame_r.instr == 8'h06 && STANDALONE_IN |=> ACCU_OUT == $past(axis_rd) && !REPLY_VALID_OUT;
	endproperty
	a_axis_read_standalone: assert property (p_axis_read_standalone) else $error("accumulator not loaded");

	property p_persist;
		@(posedge CORE_CLK_IN) disable iff (!RESETN_IN)
		cmd_ok && frame_r.instr == 8'h07 |=> axis_ee[$past(frame_r.ptype)] == $past(axis_rd);
	endproperty
	a_persist: assert property (p_persist) else $error("persist did not reach EEPROM");

	property p_reload;
		@(posedge CORE_CLK_IN) disable iff (!RESETN_IN)
		cmd_ok && frame_r.instr == 8'h08 |=> axis_mem[$past(frame_r.ptype)] == $past(ee_rd);
	endproperty
	a_reload: assert property (p_reload) else $error("reload did not restore value");

	property p_global_read;
		@(posedge CORE_CLK_IN) disable iff (!RESETN_IN)
		cmd_ok && frame_r.instr == 8'h0a |=> ACCU_OUT == $past(glob_rd);
	endproperty
	a_global_read: assert property (p_global_read) else $error("global read missed accumulator");

	property p_init_gate;
		@(posedge CORE_CLK_IN) disable iff (!RESETN_IN)
		state_r == ST_INIT |-> !RX_READY_OUT && axis_mem[init_idx_r - 8'h01] == axis_ee[init_idx_r - 8'h01]
			|| init_idx_r == 8'h00;
	endproperty
	a_init_gate: assert property (p_init_gate) else $error("load from EEPROM incomplete");

endmodule

/* File: src/param_cmd_pkg.sv */
// Shared constants and carriers for the parameter access command unit
package param_cmd_pkg;

	localparam int          FRAME_BYTES   = 9;
	localparam int          PARAM_COUNT   = 256;
	localparam logic [7:0]  SERIAL_ADDR_PARAM = 8'h42;
	localparam logic [31:0] SERIAL_ADDR_RESET = 32'h0000_0001;

	localparam logic [7:0]  INSTR_AXIS_PARAM_WRITE   = 8'h05;
	localparam logic [7:0]  INSTR_AXIS_PARAM_READ    = 8'h06;
	localparam logic [7:0]  INSTR_AXIS_PARAM_PERSIST = 8'h07;
	localparam logic [7:0]  INSTR_AXIS_PARAM_RELOAD  = 8'h08;
	localparam logic [7:0]  INSTR_GLOBAL_PARAM_WRITE = 8'h09;
	localparam logic [7:0]  INSTR_GLOBAL_PARAM_READ  = 8'h0a;

	localparam logic [7:0]  BANK_MODULE    = 8'h00;
	localparam logic [7:0]  BANK_USER_VARS = 8'h02;
	localparam logic [7:0]  BANK_IRQ_CFG   = 8'h03;
	localparam logic [7:0]  MOTOR_ONLY     = 8'h00;

	localparam logic [7:0]  STATUS_OK        = 8'h64;
	localparam logic [7:0]  STATUS_BAD_CSUM  = 8'h01;
	localparam logic [7:0]  STATUS_BAD_INSTR = 8'h02;
	localparam logic [7:0]  STATUS_BAD_VALUE = 8'h04;

	typedef struct packed {
		logic [7:0]  target;
		logic [7:0]  instr;
		logic [7:0]  ptype;
		logic [7:0]  bank;
		logic [31:0] value;
		logic [7:0]  csum;
	} frame_t;

	typedef struct packed {
		logic [7:0]  status;
		logic [7:0]  instr;
		logic [31:0] value;
	} reply_t;

endpackage

/* File: tb/host_frame_sender.sv */
// Host model that sends parameter command frames byte by byte
`timescale 1ns/1ps
module host_frame_sender
	import param_cmd_pkg::*;
(
	input  wire logic                  clk_in,     // System clock
	input  wire logic                  resetn_in,  // Reset, active low
	input  wire param_cmd_pkg::frame_t frame_in,   // Frame to send, checksum field unused
	input  wire logic                  go_in,      // Start sending frame_in
	input  wire logic                  corrupt_in, // Send a wrong checksum
	input  wire logic                  slow_in,    // Idle cycle after every byte
	input  wire logic                  ready_in,   // Unit accepts bytes
	output logic [7:0]                 byte_out,   // Frame byte
	output logic                       valid_out,  // Byte strobe
	output logic                       busy_out    // Frame in progress
);
	import param_cmd_pkg::*;
	frame_t          f_r;
	logic [3:0]      idx_r;
	logic [7:0]      sum;
	logic [0:8][7:0] b;
	assign sum = f_r.target + f_r.instr + f_r.ptype + f_r.bank + f_r.value[31:24] + f_r.value[23:16]
		+ f_r.value[15:8] + f_r.value[7:0];
	assign b = {f_r.target, f_r.instr, f_r.ptype, f_r.bank, f_r.value, sum + {7'h0, corrupt_in}};
	// A byte is held until taken; between bytes the line shows the inverse of the last one
	always_ff @(posedge clk_in or negedge resetn_in)
		if (!resetn_in)
		begin
			f_r <= '0;
			idx_r <= 4'h0;
			busy_out <= 1'b0;
			valid_out <= 1'b0;
			byte_out <= 8'h00;
		end
		else if (go_in && !busy_out)
		begin
			f_r <= frame_in;
			idx_r <= 4'h0;
			busy_out <= 1'b1;
		end
		else if (valid_out && ready_in)
		begin
			idx_r <= idx_r + 4'h1;
			busy_out <= (idx_r != 4'h8);
			valid_out <= (idx_r != 4'h8) && !slow_in;
			byte_out <= (idx_r != 4'h8 && !slow_in) ? b[idx_r + 4'h1] : ~byte_out;
		end
		else if (busy_out && !valid_out)
		begin
			valid_out <= 1'b1;
			byte_out <= b[idx_r];
		end
endmodule

/* File: tb/param_access_command_unit_test.sv */
// Self-checking bench for the parameter access command unit
`timescale 1ns/1ps
module param_access_command_unit_test;
	import param_cmd_pkg::*;
	typedef struct packed {logic [7:0] ins, typ, bnk; logic [31:0] val; logic [7:0] st; logic [31:0] rv, acc;} row_t;
	logic       clk = 1'b0;
	logic       resetn = 1'b1;
	logic       standalone = 1'b0;
	logic       go = 1'b0;
	logic       bad = 1'b0;
	logic       slow = 1'b0;
	frame_t     frm = '0;
	logic [7:0] rx_byte;
	logic       rx_valid, rx_ready, rep_valid, got, busy;
	reply_t     rep_now, rep;
	logic [31:0] accu;
	row_t       r;
	int         fails = 0;
	int         check_count = 0;
	int         cyc = 0;
	row_t rows [17] = '{
		'{8'h05, 8'h04, 8'h00, 32'h3e8, 8'h64, 32'h0, 32'h0},
		'{8'h06, 8'h04, 8'h00, 32'h0, 8'h64, 32'h3e8, 32'h0},
		'{8'h07, 8'h04, 8'h00, 32'h0, 8'h64, 32'h0, 32'h0},
		'{8'h05, 8'h04, 8'h00, 32'h1234, 8'h64, 32'h0, 32'h0},
		'{8'h06, 8'h04, 8'h00, 32'h0, 8'h64, 32'h1234, 32'h0},
		'{8'h08, 8'h04, 8'h00, 32'h0, 8'h64, 32'h0, 32'h0},
		'{8'h06, 8'h04, 8'h00, 32'h0, 8'h64, 32'h3e8, 32'h0},
		'{8'h09, 8'h07, 8'h02, 32'hdeadbeef, 8'h64, 32'h0, 32'h0},
		'{8'h0a, 8'h07, 8'h02, 32'h0, 8'h64, 32'hdeadbeef, 32'hdeadbeef},
		'{8'h09, 8'h01, 8'h03, 32'h5, 8'h64, 32'h0, 32'hdeadbeef},
		'{8'h0a, 8'h01, 8'h03, 32'h0, 8'h64, 32'h5, 32'h5},
		'{8'h09, 8'h03, 8'h00, 32'h77, 8'h64, 32'h0, 32'h5},
		'{8'h0a, 8'h03, 8'h00, 32'h0, 8'h64, 32'h77, 32'h77},
		'{8'h0a, 8'h42, 8'h00, 32'h0, 8'h64, 32'h1, 32'h1},
		'{8'h0b, 8'h00, 8'h00, 32'h0, 8'h02, 32'h0, 32'h1},
		'{8'h05, 8'h04, 8'h01, 32'h5, 8'h04, 32'h0, 32'h1},
		'{8'h09, 8'h01, 8'h01, 32'h5, 8'h04, 32'h0, 32'h1}};

	host_frame_sender host (.clk_in(clk), .resetn_in(resetn), .frame_in(frm), .go_in(go), .corrupt_in(bad),
		.slow_in(slow), .ready_in(rx_ready), .byte_out(rx_byte), .valid_out(rx_valid), .busy_out(busy));
	param_access_command_unit dut (.CORE_CLK_IN(clk), .RESETN_IN(resetn), .RX_BYTE_IN(rx_byte),
		.RX_VALID_IN(rx_valid), .STANDALONE_IN(standalone), .RX_READY_OUT(rx_ready),
		.REPLY_VALID_OUT(rep_valid), .REPLY_OUT(rep_now), .ACCU_OUT(accu));

	always #4 clk = ~clk;

	task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] seen);
		check_count++;
		if (seen !== exp)
		begin
			fails++;
			$display("wrong value %s expected %h seen %h", name, exp, seen);
		end
	endtask

	task automatic run(input logic [7:0] tgt, input logic [7:0] ins, input logic [7:0] typ,
		input logic [7:0] bnk, input logic [31:0] val);
		@(posedge clk);
		frm <= '{tgt, ins, typ, bnk, val, 8'h00};
		go <= 1'b1;
		@(posedge clk);
		go <= 1'b0;
		got = 1'b0;
		for (int i = 0; i < 50 && !got; i++)
		begin
			@(negedge clk);
			if (rep_valid === 1'b1)
			begin
				got = 1'b1;
				rep = rep_now;
			end
		end
	endtask

	task automatic do_reset();
		@(posedge clk);
		resetn <= 1'b0;
		repeat (20) @(posedge clk);
		resetn <= 1'b1;
		repeat (100) @(negedge clk);
		chk("ready during load", 32'h0, {31'h0, rx_ready});
		for (int i = 0; i < 400 && rx_ready !== 1'b1; i++)
			@(negedge clk);
		chk("ready after load", 32'h1, {31'h0, rx_ready});
	endtask

	task automatic test_done();
		if (fails == 0 && check_count > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	always @(posedge clk)
	begin
		cyc++;
		if (cyc == 6000)
		begin
			fails++;
			test_done();
		end
	end

	initial
	begin
		resetn <= 1'b0;
		do_reset();
		for (int i = 0; i < 17; i++)
		begin
			r = rows[i];
			run(8'h01, r.ins, r.typ, r.bnk, r.val);
			chk("reply seen", 32'h1, {31'h0, got});
			chk("status", {24'h0, r.st}, {24'h0, rep.status});
			chk("reply instr", {24'h0, r.ins}, {24'h0, rep.instr});
			chk("reply value", r.rv, rep.value);
			chk("accumulator", r.acc, accu);
		end
		@(posedge clk);
		bad <= 1'b1;
		run(8'h01, 8'h05, 8'h09, 8'h00, 32'h55);
		chk("bad checksum status", 32'h1, {24'h0, rep.status});
		@(posedge clk);
		bad <= 1'b0;
		run(8'h01, 8'h06, 8'h09, 8'h00, 32'h0);
		chk("untouched param", 32'h0, rep.value);
		run(8'h01, 8'h09, 8'h42, 8'h00, 32'h3);
		chk("address write status", 32'h64, {24'h0, rep.status});
		run(8'h01, 8'h06, 8'h04, 8'h00, 32'h0);
		chk("old address ignored", 32'h0, {31'h0, got});
		@(posedge clk);
		slow <= 1'b1;
		run(8'h03, 8'h06, 8'h04, 8'h00, 32'h0);
		chk("new address value", 32'h3e8, rep.value);
		@(posedge clk);
		slow <= 1'b0;
		standalone <= 1'b1;
		run(8'h03, 8'h06, 8'h04, 8'h00, 32'h0);
		chk("standalone silent", 32'h0, {31'h0, got});
		chk("standalone accumulator", 32'h3e8, accu);
		@(posedge clk);
		standalone <= 1'b0;
		do_reset();
		run(8'h01, 8'h06, 8'h04, 8'h00, 32'h0);
		chk("value after load", 32'h0, rep.value);
		test_done();
	end
endmodule
